//--- rtl/fbmf_regs.vh
`ifndef FBMF_REGS_VH
`define FBMF_REGS_VH

// ********************************************************************
// Image geometry
// ********************************************************************
`define FBMF_IMG_BYTES 10'h12C
`define FBMF_FRAG_MAX 4'h8
`define FBMF_WORD_SHIFT 1'h0

// ********************************************************************
// Bit rate, clock and rate figures in kHz
// ********************************************************************
`define FBMF_CLK_KHZ 32'h61A8
`define FBMF_RATE_125_KHZ 32'h7D
`define FBMF_RATE_250_KHZ 32'hFA
`define FBMF_RATE_500_KHZ 32'h1F4
`define FBMF_SEL_250 2'h1
`define FBMF_SEL_500 2'h2

// ********************************************************************
// Error codes
// ********************************************************************
`define FBMF_ERR_MAP 2'h1
`define FBMF_ERR_SIZE 2'h2
`define FBMF_ERR_OVF 2'h3

`endif

//--- rtl/fbmf_byte_ram.v
`timescale 1ns/1ps
`include "fbmf_regs.vh"

module fbmf_byte_ram (
  input wire clk_in,
  input wire wr_en_in,
  input wire [8:0] wr_addr_in,
  input wire [7:0] wr_data_in,
  input wire [8:0] rd_addr_in,
  output reg [7:0] rd_data_out
);
  reg [7:0] mem [0:`FBMF_IMG_BYTES-10'h001];

  // Addresses past the image are dropped rather than aliased
  always @(posedge clk_in) begin
    if (wr_en_in && ({1'h0, wr_addr_in} < `FBMF_IMG_BYTES)) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    if ({1'h0, rd_addr_in} < `FBMF_IMG_BYTES) begin
      rd_data_out <= mem[rd_addr_in];
    end else begin
      rd_data_out <= 8'h00;
    end
  end
endmodule // fbmf_byte_ram

//--- rtl/fbmf_fragmenter.v
`timescale 1ns/1ps
`include "fbmf_regs.vh"

module fbmf_fragmenter (
  input wire ref_clk_in,
  input wire rst_in,
  input wire [1:0] rate_sel_in,
  output reg bit_tick_out,
  input wire [8:0] out_bit_blk_start_in,
  input wire [9:0] out_bit_blk_bytes_in,
  input wire [8:0] out_word_blk_start_in,
  input wire [8:0] out_word_blk_words_in,
  input wire [8:0] in_bit_blk_start_in,
  input wire [9:0] in_bit_blk_bytes_in,
  input wire [8:0] in_word_blk_start_in,
  input wire [8:0] in_word_blk_words_in,
  input wire host_out_wr_in,
  input wire [8:0] host_out_addr_in,
  input wire [7:0] host_out_data_in,
  input wire [8:0] host_in_addr_in,
  output wire [7:0] host_in_data_out,
  input wire msg_req_in,
  input wire msg_explicit_in,
  input wire [5:0] msg_node_in,
  input wire [8:0] msg_bit_start_in,
  input wire [9:0] msg_bit_bytes_in,
  input wire [8:0] msg_word_start_in,
  input wire [8:0] msg_word_words_in,
  output reg msg_busy_out,
  output reg msg_done_out,
  output reg tx_err_out,
  output reg [1:0] tx_err_code_out,
  output reg frag_valid_out,
  input wire frag_ready_in,
  output reg [5:0] frag_node_out,
  output reg frag_explicit_out,
  output reg [5:0] frag_index_out,
  output reg frag_first_out,
  output reg frag_last_out,
  output reg [3:0] frag_len_out,
  output reg [63:0] frag_data_out,
  input wire ack_in,
  input wire rx_valid_in,
  output reg rx_ready_out,
  input wire rx_first_in,
  input wire rx_explicit_in,
  input wire [3:0] rx_len_in,
  input wire [63:0] rx_data_in,
  input wire [8:0] rx_bit_start_in,
  input wire [9:0] rx_bit_bytes_in,
  input wire [8:0] rx_word_start_in,
  input wire [8:0] rx_word_words_in,
  output reg ack_out,
  output reg rx_err_out,
  output reg [1:0] rx_err_code_out
);
  // ******************************************************************
  // Bit rate divider
  // ******************************************************************
  localparam [31:0] DIV_125_W = `FBMF_CLK_KHZ / `FBMF_RATE_125_KHZ;
  localparam [31:0] DIV_250_W = `FBMF_CLK_KHZ / `FBMF_RATE_250_KHZ;
  localparam [31:0] DIV_500_W = `FBMF_CLK_KHZ / `FBMF_RATE_500_KHZ;
  localparam [7:0] DIV_125 = DIV_125_W[7:0];
  localparam [7:0] DIV_250 = DIV_250_W[7:0];
  localparam [7:0] DIV_500 = DIV_500_W[7:0];
  reg [7:0] div_cnt;
  wire [7:0] div_top = (rate_sel_in == `FBMF_SEL_500) ? DIV_500 :
                       (rate_sel_in == `FBMF_SEL_250) ? DIV_250 : DIV_125;

  // Undefined select falls back to the slowest rate
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt <= 8'h00;
      bit_tick_out <= 1'h0;
    end else if (div_cnt >= div_top - 8'h01) begin
      div_cnt <= 8'h00;
      bit_tick_out <= 1'h1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      bit_tick_out <= 1'h0;
    end
  end

  // ******************************************************************
  // Map checks
  // ******************************************************************
  function fits;
    input [8:0] s;
    input [9:0] n;
    input [8:0] bs;
    input [9:0] bn;
    reg [10:0] e;
    reg [10:0] be;
    begin
      e = {2'h0, s} + {1'h0, n};
      be = {2'h0, bs} + {1'h0, bn};
      fits = (s >= bs) && (e <= be) && (be <= {1'h0, `FBMF_IMG_BYTES});
    end
  endfunction

  // Words count two bytes each; bit blocks are already whole bytes
  wire [9:0] out_wblk_bytes = {out_word_blk_words_in, `FBMF_WORD_SHIFT};
  wire [9:0] in_wblk_bytes = {in_word_blk_words_in, `FBMF_WORD_SHIFT};
  wire [10:0] out_sum = {1'h0, out_bit_blk_bytes_in} + {1'h0, out_wblk_bytes};
  wire [10:0] in_sum = {1'h0, in_bit_blk_bytes_in} + {1'h0, in_wblk_bytes};
  wire out_size_ok = out_sum <= {1'h0, `FBMF_IMG_BYTES};
  wire in_size_ok = in_sum <= {1'h0, `FBMF_IMG_BYTES};
  wire [9:0] msg_wbytes = {msg_word_words_in, `FBMF_WORD_SHIFT};
  wire [9:0] rx_wbytes = {rx_word_words_in, `FBMF_WORD_SHIFT};
  wire msg_map_ok = fits(msg_bit_start_in, msg_bit_bytes_in,
                         out_bit_blk_start_in, out_bit_blk_bytes_in) &&
                    fits(msg_word_start_in, msg_wbytes,
                         out_word_blk_start_in, out_wblk_bytes);
  wire rx_map_ok_now = fits(rx_bit_start_in, rx_bit_bytes_in,
                            in_bit_blk_start_in, in_bit_blk_bytes_in) &&
                       fits(rx_word_start_in, rx_wbytes,
                            in_word_blk_start_in, in_wblk_bytes);

  // ******************************************************************
  // Transmit side
  // ******************************************************************
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_DATA = 3'h2;
  localparam [2:0] S_SEND = 3'h3;
  localparam [2:0] S_ACK = 3'h4;
  reg [2:0] tx_state;
  reg [9:0] tx_pos;
  reg [9:0] tx_total;
  reg [8:0] tx_bit_start;
  reg [9:0] tx_bit_len;
  reg [8:0] tx_word_start;
  reg [3:0] tx_byte;
  wire [7:0] tx_rd_data;
  wire [9:0] tx_woff = tx_pos - tx_bit_len;
  // Assembly order: node bit bytes first, then node word bytes
  wire [8:0] tx_rd_addr = (tx_pos < tx_bit_len) ? tx_bit_start + tx_pos[8:0] :
                          tx_word_start + tx_woff[8:0];
  wire [9:0] tx_rem = tx_total - tx_pos;
  wire [3:0] next_frag_len = (tx_rem > {6'h00, `FBMF_FRAG_MAX}) ? `FBMF_FRAG_MAX :
                             tx_rem[3:0];
  // Sum kept one bit wider so a huge request cannot wrap past the size check
  wire [10:0] req_sum = {1'h0, msg_bit_bytes_in} + {1'h0, msg_wbytes};
  wire [9:0] req_total = req_sum[9:0];
  wire tx_fragmented = tx_total > {6'h00, `FBMF_FRAG_MAX};
  wire [9:0] tx_pos_inc = tx_pos + 10'h001;

  fbmf_byte_ram out_image (
    .clk_in(ref_clk_in),
    .wr_en_in(host_out_wr_in),
    .wr_addr_in(host_out_addr_in),
    .wr_data_in(host_out_data_in),
    .rd_addr_in(tx_rd_addr),
    .rd_data_out(tx_rd_data)
  );

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_state <= S_IDLE;
      tx_pos <= 10'h000;
      tx_total <= 10'h000;
      tx_bit_start <= 9'h000;
      tx_bit_len <= 10'h000;
      tx_word_start <= 9'h000;
      tx_byte <= 4'h0;
      msg_busy_out <= 1'h0;
      msg_done_out <= 1'h0;
      tx_err_out <= 1'h0;
      tx_err_code_out <= 2'h0;
      frag_valid_out <= 1'h0;
      frag_node_out <= 6'h00;
      frag_explicit_out <= 1'h0;
      frag_index_out <= 6'h00;
      frag_first_out <= 1'h0;
      frag_last_out <= 1'h0;
      frag_len_out <= 4'h0;
      frag_data_out <= 64'h0000000000000000;
    end else begin
      msg_done_out <= 1'h0;
      tx_err_out <= 1'h0;
      case (tx_state)
        S_IDLE: begin
          if (msg_req_in) begin
            if (!out_size_ok || (req_sum > {1'h0, `FBMF_IMG_BYTES})) begin
              tx_err_out <= 1'h1;
              tx_err_code_out <= `FBMF_ERR_SIZE;
            end else if (!msg_map_ok) begin
              tx_err_out <= 1'h1;
              tx_err_code_out <= `FBMF_ERR_MAP;
            end else begin
              msg_busy_out <= 1'h1;
              tx_pos <= 10'h000;
              tx_total <= req_total;
              tx_bit_start <= msg_bit_start_in;
              tx_bit_len <= msg_bit_bytes_in;
              tx_word_start <= msg_word_start_in;
              tx_byte <= 4'h0;
              frag_node_out <= msg_node_in;
              frag_explicit_out <= msg_explicit_in;
              frag_index_out <= 6'h00;
              frag_first_out <= 1'h1;
              frag_data_out <= 64'h0000000000000000;
              // An empty message still goes out as one zero-length packet
              if (req_total == 10'h000) begin
                frag_len_out <= 4'h0;
                frag_last_out <= 1'h1;
                frag_valid_out <= 1'h1;
                tx_state <= S_SEND;
              end else begin
                frag_len_out <= (req_total > {6'h00, `FBMF_FRAG_MAX}) ?
                                `FBMF_FRAG_MAX : req_total[3:0];
                tx_state <= S_ADDR;
              end
            end
          end
        end
        S_ADDR: begin
          tx_state <= S_DATA;
        end
        S_DATA: begin
          frag_data_out[{tx_byte[2:0], 3'h0} +: 8] <= tx_rd_data;
          tx_pos <= tx_pos_inc;
          tx_byte <= tx_byte + 4'h1;
          if (tx_byte + 4'h1 == frag_len_out) begin
            frag_last_out <= (tx_pos_inc == tx_total);
            frag_valid_out <= 1'h1;
            tx_state <= S_SEND;
          end else begin
            tx_state <= S_ADDR;
          end
        end
        S_SEND: begin
          if (frag_ready_in) begin
            frag_valid_out <= 1'h0;
            if (frag_explicit_out && tx_fragmented) begin
              tx_state <= S_ACK;
            end else if (frag_last_out) begin
              msg_done_out <= 1'h1;
              msg_busy_out <= 1'h0;
              tx_state <= S_IDLE;
            end else begin
              // Polled: next fragment is built at once
              frag_index_out <= frag_index_out + 6'h01;
              frag_first_out <= 1'h0;
              frag_len_out <= next_frag_len;
              frag_data_out <= 64'h0000000000000000;
              tx_byte <= 4'h0;
              tx_state <= S_ADDR;
            end
          end
        end
        S_ACK: begin
          // Acks arriving outside this state are ignored
          if (ack_in) begin
            if (frag_last_out) begin
              msg_done_out <= 1'h1;
              msg_busy_out <= 1'h0;
              tx_state <= S_IDLE;
            end else begin
              frag_index_out <= frag_index_out + 6'h01;
              frag_first_out <= 1'h0;
              frag_len_out <= next_frag_len;
              frag_data_out <= 64'h0000000000000000;
              tx_byte <= 4'h0;
              tx_state <= S_ADDR;
            end
          end
        end
        default: begin
          tx_state <= S_IDLE;
        end
      endcase
    end
  end

  // ******************************************************************
  // Receive side
  // ******************************************************************
  localparam [1:0] R_IDLE = 2'h0;
  localparam [1:0] R_WRITE = 2'h1;
  reg [1:0] rx_state;
  reg [9:0] rx_pos;
  reg [8:0] rx_bit_start;
  reg [9:0] rx_bit_len;
  reg [8:0] rx_word_start;
  reg [9:0] rx_total;
  reg rx_map_ok;
  reg rx_explicit;
  reg [3:0] rx_len;
  reg [3:0] rx_byte;
  reg [63:0] rx_data;
  reg rx_ovf;
  wire [9:0] rx_woff = rx_pos - rx_bit_len;
  wire [8:0] rx_wr_addr = (rx_pos < rx_bit_len) ? rx_bit_start + rx_pos[8:0] :
                          rx_word_start + rx_woff[8:0];
  wire rx_in_range = rx_pos < rx_total;
  // No write in the closing cycle, where rx_byte already points past the packet
  wire rx_wr_en = (rx_state == R_WRITE) && rx_map_ok && rx_in_range && (rx_byte != rx_len);

  fbmf_byte_ram in_image (
    .clk_in(ref_clk_in),
    .wr_en_in(rx_wr_en),
    .wr_addr_in(rx_wr_addr),
    .wr_data_in(rx_data[{rx_byte[2:0], 3'h0} +: 8]),
    .rd_addr_in(host_in_addr_in),
    .rd_data_out(host_in_data_out)
  );

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_state <= R_IDLE;
      rx_pos <= 10'h000;
      rx_bit_start <= 9'h000;
      rx_bit_len <= 10'h000;
      rx_word_start <= 9'h000;
      rx_total <= 10'h000;
      rx_map_ok <= 1'h0;
      rx_explicit <= 1'h0;
      rx_len <= 4'h0;
      rx_byte <= 4'h0;
      rx_data <= 64'h0000000000000000;
      rx_ovf <= 1'h0;
      rx_ready_out <= 1'h0;
      ack_out <= 1'h0;
      rx_err_out <= 1'h0;
      rx_err_code_out <= 2'h0;
    end else begin
      ack_out <= 1'h0;
      rx_err_out <= 1'h0;
      case (rx_state)
        R_IDLE: begin
          rx_ready_out <= 1'h1;
          if (rx_valid_in && rx_ready_out) begin
            rx_ready_out <= 1'h0;
            rx_data <= rx_data_in;
            rx_len <= (rx_len_in > `FBMF_FRAG_MAX) ? `FBMF_FRAG_MAX : rx_len_in;
            rx_byte <= 4'h0;
            rx_explicit <= rx_explicit_in;
            rx_ovf <= 1'h0;
            if (rx_first_in) begin
              rx_pos <= 10'h000;
              rx_bit_start <= rx_bit_start_in;
              rx_bit_len <= rx_bit_bytes_in;
              rx_word_start <= rx_word_start_in;
              rx_total <= rx_bit_bytes_in + rx_wbytes;
              rx_map_ok <= rx_map_ok_now && in_size_ok;
              if (!(rx_map_ok_now && in_size_ok)) begin
                rx_err_out <= 1'h1;
                rx_err_code_out <= `FBMF_ERR_MAP;
              end
            end
            rx_state <= R_WRITE;
          end
        end
        R_WRITE: begin
          // Bytes beyond the node's sub-block are dropped, never spilled
          if (rx_byte == rx_len) begin
            if (rx_ovf) begin
              rx_err_out <= 1'h1;
              rx_err_code_out <= `FBMF_ERR_OVF;
            end
            ack_out <= rx_explicit;
            rx_ready_out <= 1'h1;
            rx_state <= R_IDLE;
          end else begin
            if (!rx_in_range) begin
              rx_ovf <= 1'h1;
            end
            rx_pos <= rx_pos + 10'h001;
            rx_byte <= rx_byte + 4'h1;
          end
        end
        default: begin
          rx_state <= R_IDLE;
        end
      endcase
    end
  end
endmodule // fbmf_fragmenter

//--- bench/fbmf_chk_sva.sv
`timescale 1ns/1ps
module fbmf_chk (
  input wire ref_clk_in,
  input wire rst_in,
  input wire bit_tick_out,
  input wire frag_valid_out,
  input wire frag_ready_in,
  input wire frag_explicit_out,
  input wire frag_last_out,
  input wire [3:0] frag_len_out,
  input wire [63:0] frag_data_out,
  input wire ack_in,
  input wire rx_valid_in,
  input wire rx_ready_out,
  input wire rx_explicit_in,
  input wire ack_out
);
  // ********************************************************************
  // Explicit hold-off tracking
  // ********************************************************************
  reg wait_ack;
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in)
      wait_ack <= 1'b0;
    else if (frag_valid_out && frag_ready_in && frag_explicit_out && !frag_last_out)
      wait_ack <= 1'b1;
    else if (ack_in)
      wait_ack <= 1'b0;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  chk_tick_pulse: assert property (bit_tick_out |=> !bit_tick_out [*8])
    else $error("bit tick longer than one cycle or too close");
  chk_len_max: assert property (frag_valid_out |-> frag_len_out <= 4'h8)
    else $error("fragment longer than eight bytes");
  chk_split_full: assert property (frag_valid_out && !frag_last_out |-> frag_len_out == 4'h8)
    else $error("non-final fragment not full");
  chk_frag_stands: assert property (frag_valid_out && !frag_ready_in |=>
    frag_valid_out && $stable(frag_data_out) && $stable(frag_len_out))
    else $error("fragment changed before accepted");
  chk_poll_next: assert property (frag_valid_out && frag_ready_in && !frag_explicit_out &&
    !frag_last_out |-> ##[2:24] frag_valid_out)
    else $error("polled fragment not followed promptly");
  chk_ack_hold: assert property (wait_ack |-> !frag_valid_out)
    else $error("explicit fragment sent before acknowledge");
  chk_ack_next: assert property (wait_ack && ack_in |-> ##[1:24] frag_valid_out)
    else $error("acknowledge did not release next fragment");
  chk_rx_ack: assert property (rx_valid_in && rx_ready_out && rx_explicit_in |->
    ##[1:10] ack_out)
    else $error("explicit fragment not acknowledged");
  chk_rx_noack: assert property (rx_valid_in && rx_ready_out && !rx_explicit_in |=>
    !ack_out [*8])
    else $error("polled fragment acknowledged");
  cov_poll: cover property (frag_valid_out && frag_ready_in && !frag_explicit_out && frag_last_out);
  cov_expl: cover property (wait_ack && ack_in);
  cov_rx: cover property (rx_valid_in && rx_ready_out && rx_explicit_in);
endmodule // fbmf_chk

bind fbmf_fragmenter fbmf_chk i_fbmf_chk (.*);

//--- bench/fbmf_node.sv
`timescale 1ns/1ps
module fbmf_node (
  input wire clk_in,
  input wire rst_in,
  input wire frag_valid_in,
  input wire frag_explicit_in,
  input int ready_dly_in,
  input int ack_dly_in,
  output logic frag_ready_out,
  output logic node_ack_out
);
  // ********************************************************************
  // Node behaviour
  // ********************************************************************
  logic expl;
  task step;
    @(posedge clk_in);
    #1;
  endtask
  // Flag is copied while the fragment stands; it holds only until the next fragment is seen
  initial begin
    frag_ready_out = 1'b0;
    node_ack_out = 1'b0;
    forever begin
      step;
      if (rst_in === 1'b0 && frag_valid_in === 1'b1) begin
        expl = frag_explicit_in;
        repeat (ready_dly_in) step;
        frag_ready_out = 1'b1;
        step;
        frag_ready_out = 1'b0;
        if (expl === 1'b1) begin
          repeat (ack_dly_in) step;
          node_ack_out = 1'b1;
          step;
          node_ack_out = 1'b0;
        end
      end
    end
  end
endmodule // fbmf_node

//--- bench/tb_fbmf_fragmenter.sv
`timescale 1ns/1ps
`include "fbmf_regs.vh"
module tb_fbmf_fragmenter;
  // ********************************************************************
  // Signals and instances
  // ********************************************************************
  logic ref_clk_in, rst_in, host_out_wr_in, msg_req_in, msg_explicit_in;
  logic rx_valid_in, rx_first_in, rx_explicit_in, frag_ready_in, ack_in;
  logic [1:0] rate_sel_in;
  logic [8:0] out_bit_blk_start_in, out_word_blk_start_in, in_bit_blk_start_in;
  logic [8:0] in_word_blk_start_in, host_out_addr_in, host_in_addr_in, msg_bit_start_in;
  logic [8:0] msg_word_start_in, rx_bit_start_in, rx_word_start_in, out_word_blk_words_in;
  logic [8:0] in_word_blk_words_in, msg_word_words_in, rx_word_words_in;
  logic [9:0] out_bit_blk_bytes_in, in_bit_blk_bytes_in, msg_bit_bytes_in, rx_bit_bytes_in;
  logic [7:0] host_out_data_in;
  logic [5:0] msg_node_in;
  logic [3:0] rx_len_in;
  logic [63:0] rx_data_in;
  wire bit_tick_out, msg_busy_out, msg_done_out, tx_err_out, frag_valid_out, frag_explicit_out;
  wire frag_first_out, frag_last_out, rx_ready_out, ack_out, rx_err_out;
  wire [1:0] tx_err_code_out, rx_err_code_out;
  wire [5:0] frag_node_out, frag_index_out;
  wire [3:0] frag_len_out;
  wire [63:0] frag_data_out;
  wire [7:0] host_in_data_out;
  int failures, checks_done, nf, k, i, rdly, adly;
  logic [63:0] got_d [0:3];
  logic [3:0] got_l [0:3];
  logic [14:0] got_x [0:3];
  logic [63:0] e [0:1];
  logic [1:0] r_sel [0:3] = '{2'h0, 2'h1, 2'h2, 2'h3};
  int r_per [0:3] = '{200, 100, 50, 200};
  fbmf_fragmenter i_fbmf_fragmenter (.*);
  fbmf_node i_fbmf_node (.clk_in(ref_clk_in), .rst_in(rst_in), .frag_valid_in(frag_valid_out),
    .frag_explicit_in(frag_explicit_out), .ready_dly_in(rdly), .ack_dly_in(adly),
    .frag_ready_out(frag_ready_in), .node_ack_out(ack_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    if (frag_valid_out === 1'b1 && frag_ready_in === 1'b1 && nf < 4) begin
      got_d[nf] <= frag_data_out;
      got_l[nf] <= frag_len_out;
      got_x[nf] <= {frag_node_out, frag_explicit_out, frag_first_out, frag_last_out,
                    frag_index_out};
      nf <= nf + 1;
    end
  end
  task step;
    @(posedge ref_clk_in);
    #1;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task bound(input int n);
    if (n >= 400) begin
      failures++;
      test_done;
    end
  endtask
  task send(input logic ex, input logic [9:0] bb, input logic [8:0] ww);
    msg_explicit_in = ex;
    msg_bit_bytes_in = bb;
    msg_word_words_in = ww;
    msg_req_in = 1'b1;
    nf = 0;
    step;
    msg_req_in = 1'b0;
    for (k = 0; k < 400 && msg_done_out !== 1'b1 && tx_err_out !== 1'b1; k++)
      step;
    bound(k);
  endtask
  // Bit bytes 1..2 then word bytes 4..11, image bytes 0..19 hold 30h plus their address
  task frags(input logic ex);
    chk(nf, 2);
    chk(got_l[0], 4'h8);
    chk(got_d[0], e[0]);
    chk(got_l[1], 4'h2);
    chk(got_d[1], e[1]);
    chk(got_x[0], {6'h2A, ex, 1'b1, 1'b0, 6'h00});
    chk(got_x[1], {6'h2A, ex, 1'b0, 1'b1, 6'h01});
    chk(msg_busy_out, 1'b0);
  endtask
  task rx(input logic ex, input logic [3:0] n, input logic [63:0] d);
    rx_explicit_in = ex;
    rx_len_in = n;
    rx_data_in = d;
    rx_first_in = 1'b1;
    rx_valid_in = 1'b1;
    step;
    rx_valid_in = 1'b0;
    for (k = 0; k < 400 && rx_ready_out !== 1'b1; k++)
      step;
    bound(k);
  endtask
  task rd(input logic [8:0] a, input logic [7:0] x);
    host_in_addr_in = a;
    step;
    chk(host_in_data_out, x);
  endtask
  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    {host_out_wr_in, msg_req_in, msg_explicit_in, rx_valid_in, rx_first_in} = 5'h00;
    {rx_explicit_in, rate_sel_in, host_out_addr_in, host_in_addr_in} = 21'h000000;
    {out_bit_blk_start_in, out_word_blk_start_in, in_bit_blk_start_in} = 27'h0000000;
    {in_word_blk_start_in, msg_bit_start_in, msg_word_start_in} = {9'h000, 9'h001, 9'h004};
    {out_bit_blk_bytes_in, in_bit_blk_bytes_in, out_word_blk_words_in} = {10'h004, 10'h004, 9'h008};
    {in_word_blk_words_in, msg_word_words_in, msg_bit_bytes_in} = {9'h008, 9'h004, 10'h002};
    {rx_bit_start_in, rx_bit_bytes_in, rx_word_start_in, rx_word_words_in} = {9'h0, 10'h2, 9'h6, 9'h1};
    {host_out_data_in, msg_node_in, rx_len_in, rx_data_in} = 82'h0;
    {failures, checks_done, nf, rdly, adly} = '0;
    e[0] = 64'h0;
    e[1] = 64'h0;
    for (k = 0; k < 10; k++)
      e[k / 8][8 * (k % 8) +: 8] = 8'h30 + ((k < 2) ? k + 1 : k + 2);
    rst_in = 1'b1;
    repeat (10) step;
    chk({msg_busy_out, frag_valid_out, ack_out, rx_ready_out, tx_err_out}, 5'h00);
    rst_in = 1'b0;
    step;
    chk(rx_ready_out, 1'b1);
    for (i = 0; i < 4; i++) begin
      rate_sel_in = r_sel[i];
      repeat (3) begin
        step;
        for (k = 1; k < 400 && bit_tick_out !== 1'b1; k++)
          step;
        bound(k);
      end
      chk(k, r_per[i]);
    end
    host_out_wr_in = 1'b1;
    for (i = 0; i < 20; i++) begin
      host_out_addr_in = i;
      host_out_data_in = 8'h30 + i;
      step;
    end
    host_out_wr_in = 1'b0;
    msg_node_in = 6'h2A;
    send(1'b0, 10'h002, 9'h004);
    frags(1'b0);
    rdly = 2;
    adly = 4;
    send(1'b1, 10'h002, 9'h004);
    frags(1'b1);
    send(1'b0, 10'h000, 9'h000);
    chk(nf, 1);
    chk(got_l[0], 4'h0);
    chk(got_x[0], {6'h2A, 1'b0, 1'b1, 1'b1, 6'h00});
    send(1'b0, 10'h12D, 9'h000);
    chk(tx_err_code_out, `FBMF_ERR_SIZE);
    send(1'b0, 10'h004, 9'h000);
    chk(tx_err_code_out, `FBMF_ERR_MAP);
    rx(1'b1, 4'h3, 64'h0000_0000_00A3_A2A1);
    chk(ack_out, 1'b1);
    rd(9'h000, 8'hA1);
    rd(9'h001, 8'hA2);
    rd(9'h006, 8'hA3);
    rx(1'b0, 4'h2, 64'h0000_0000_0000_B2B1);
    chk(ack_out, 1'b0);
    rd(9'h001, 8'hB2);
    rx(1'b0, 4'h8, 64'hC8C7_C6C5_C4C3_C2C1);
    chk(rx_err_out, 1'b1);
    chk(rx_err_code_out, `FBMF_ERR_OVF);
    rd(9'h007, 8'hC4);
    test_done;
  end
endmodule // tb_fbmf_fragmenter
